// File: design/ct_pkg.sv
/*
  Constants shared by the lowest-code tracker bank: the register map,
  reset values, field layout, bus answers and tracker widths.
  Assumes an AXI4-Lite register bus with 32-bit data.
*/
`default_nettype none

package ct_pkg;

  // Tracker geometry
  localparam int          CT_NUM_CH   = 4;
  localparam int          CT_CODE_W   = 16;
  localparam int          CT_BYTE_W   = 8;
  localparam int          CT_CHSEL_W  = 3;
  localparam int          CT_ADDR_W   = 12;
  localparam int          CT_DATA_W   = 32;
  localparam int          CT_IDX_W    = CT_ADDR_W - 2;

  // Value after reset and after a read of any lowest-code byte
  localparam logic [7:0]  CT_LOWEST_RESET = 8'hFF;

  // Register indices; byte address is four times the index
  localparam logic [CT_IDX_W-1:0] CT_IDX_IN1_LOW  = 10'h082;
  localparam logic [CT_IDX_W-1:0] CT_IDX_IN1_HIGH = 10'h083;
  localparam logic [CT_IDX_W-1:0] CT_IDX_IN2_LOW  = 10'h084;
  localparam logic [CT_IDX_W-1:0] CT_IDX_IN2_HIGH = 10'h085;
  localparam logic [CT_IDX_W-1:0] CT_IDX_IN3_LOW  = 10'h086;
  localparam logic [CT_IDX_W-1:0] CT_IDX_IN3_HIGH = 10'h087;
  localparam logic [CT_IDX_W-1:0] CT_IDX_IN4_LOW  = 10'h088;
  localparam logic [CT_IDX_W-1:0] CT_IDX_IN4_HIGH = 10'h089;

  // First input channel number served by this bank
  localparam logic [CT_CHSEL_W-1:0] CT_FIRST_CH = 3'h1;

  // AXI4-Lite answers
  localparam logic [1:0]  CT_RESP_OKAY   = 2'b00;
  localparam logic [1:0]  CT_RESP_SLVERR = 2'b10;
  localparam logic [1:0]  CT_RESP_DECERR = 2'b11;

  // Write channel states
  typedef enum logic [1:0] {
    CT_WR_IDLE = 2'b00,
    CT_WR_ADDR = 2'b01,
    CT_WR_DATA = 2'b10,
    CT_WR_RESP = 2'b11
  } ct_wr_state_e;

  // Read channel states
  typedef enum logic {
    CT_RD_IDLE = 1'b0,
    CT_RD_RESP = 1'b1
  } ct_rd_state_e;

endpackage : ct_pkg

`default_nettype wire

// File: design/ct_trk_if.sv
/*
  Link between the register slave and one lowest-code tracker:
  new conversion codes, read-clear strobes and the stored minimum.
  Assumes both ends run on clk_sys.
*/
`default_nettype none

interface ct_trk_if;
  import ct_pkg::*;

  logic                 sampleValid;
  logic [CT_CODE_W-1:0] sampleCode;
  logic                 clearLow;
  logic                 clearHigh;
  logic [CT_CODE_W-1:0] minCode;

  modport owner   (output sampleValid, sampleCode, clearLow, clearHigh, input minCode);
  modport tracker (input sampleValid, sampleCode, clearLow, clearHigh, output minCode);
endinterface : ct_trk_if

`default_nettype wire

// File: design/ct_min_tracker.sv
/*
  One channel's lowest-code holder, split into a low and a high byte
  that are each restored to all ones when software reads them.
  Assumes clear strobes and samples are one-cycle pulses on clk_sys.
*/
`default_nettype none

module ct_min_tracker
  import ct_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic nrst,
  ct_trk_if.tracker trk
);
  import ct_pkg::*;

  logic [CT_BYTE_W-1:0] minLow;
  logic [CT_BYTE_W-1:0] minHigh;
  logic [CT_BYTE_W-1:0] next_minLow;
  logic [CT_BYTE_W-1:0] next_minHigh;
  logic [CT_CODE_W-1:0] baseCode;

  // Clear first, then compare, so a sample in the clear cycle is kept if below the cleared value
  always_comb begin
    baseCode = {trk.clearHigh ? CT_LOWEST_RESET : minHigh,
                trk.clearLow  ? CT_LOWEST_RESET : minLow};
    if (trk.sampleValid && (trk.sampleCode < baseCode)) begin
      {next_minHigh, next_minLow} = trk.sampleCode;
    end else begin
      {next_minHigh, next_minLow} = baseCode;
    end
  end

  // Holder registers, all ones out of reset
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      minLow  <= CT_LOWEST_RESET;
      minHigh <= CT_LOWEST_RESET;
    end else begin
      minLow  <= next_minLow;
      minHigh <= next_minHigh;
    end
  end

  assign trk.minCode = {minHigh, minLow};

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  lower_code_taken_a: assert property (
    trk.sampleValid && !trk.clearLow && !trk.clearHigh && trk.sampleCode < trk.minCode
    |=> trk.minCode == $past(trk.sampleCode))
    else $error("lower code not stored");

  higher_code_kept_a: assert property (
    trk.sampleValid && !trk.clearLow && !trk.clearHigh && trk.sampleCode >= trk.minCode
    |=> $stable(trk.minCode))
    else $error("stored minimum moved on a higher code");

  low_clear_ones_a: assert property (
    trk.clearLow && !trk.sampleValid |=> minLow == CT_LOWEST_RESET)
    else $error("low byte not restored after read");

  high_clear_ones_a: assert property (
    trk.clearHigh && !trk.sampleValid |=> minHigh == CT_LOWEST_RESET)
    else $error("high byte not restored after read");

endmodule : ct_min_tracker

`default_nettype wire

// File: design/ct_min_bank.sv
/*
  Lowest-code register bank for input channels 1 to 4, read over an
  AXI4-Lite slave. Every byte is read-only and restored on read.
  Assumes conversion codes arrive as one-cycle strobes on clk_sys.
*/
// Function
// - Each channel keeps its lowest conversion code since its register was read.
// - Reading a lowest-code byte returns it, then restores it to all ones.
// - Bytes reset to all ones and are read-only; writes are refused.
// - Each channel: low byte at even index, high at next odd, two per channel.
`default_nettype none

module ct_min_bank
  import ct_pkg::*;
(
  input  wire logic                   clk_sys,
  input  wire logic                   nrst,
  // Conversion results from the converter core
  input  wire logic                   codeValid,
  input  wire logic [CT_CHSEL_W-1:0]  codeChannel,
  input  wire logic [CT_CODE_W-1:0]   code,
  // AXI4-Lite slave
  input  wire logic [CT_ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [CT_DATA_W-1:0]   s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [CT_ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [CT_DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready
);
  import ct_pkg::*;

  ct_trk_if trk [CT_NUM_CH] ();

  logic [CT_CODE_W-1:0] minCodes [CT_NUM_CH];
  logic                 clearLows [CT_NUM_CH];
  logic                 clearHighs [CT_NUM_CH];
  logic [2*CT_NUM_CH-1:0] clearAll;                  // Byte k of channel k/2

  // Address decode: a register sits at a whole word inside the index range
  function automatic logic addrHit(input logic [CT_ADDR_W-1:0] a);
    logic [CT_IDX_W-1:0] idx;
    idx = a[CT_ADDR_W-1:2];
    return (a[1:0] == 2'b00) && (idx >= CT_IDX_IN1_LOW) && (idx <= CT_IDX_IN4_HIGH);
  endfunction

  // Read side decode, channel from pair, byte from index parity
  logic [CT_IDX_W-1:0] rdIdx;
  logic [CT_IDX_W-1:0] rdOffs;
  logic [1:0]          rdCh;
  logic                rdHigh;
  logic                rdHit;
  logic                rdTake;

  always_comb begin
    rdIdx  = s_axi_araddr[CT_ADDR_W-1:2];
    rdOffs = rdIdx - CT_IDX_IN1_LOW;
    rdCh   = rdOffs[2:1];
    rdHigh = rdOffs[0];
    rdHit  = addrHit(s_axi_araddr);
    rdTake = s_axi_arvalid && s_axi_arready;
  end

  // One tracker per channel; a read of a byte clears that byte only
  for (genvar g = 0; g < CT_NUM_CH; g++) begin : gen_ch
    assign trk[g].sampleValid = codeValid &&
                                (codeChannel == CT_FIRST_CH + CT_CHSEL_W'(g));
    assign trk[g].sampleCode  = code;
    assign trk[g].clearLow    = clearLows[g];
    assign trk[g].clearHigh   = clearHighs[g];
    assign minCodes[g]        = trk[g].minCode;

    always_comb begin
      clearLows[g]  = rdTake && rdHit && (rdCh == 2'(g)) && !rdHigh;
      clearHighs[g] = rdTake && rdHit && (rdCh == 2'(g)) && rdHigh;
    end

    ct_min_tracker u_trk (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .trk     (trk[g])
    );
  end

  // Clear strobes packed two per channel, for the checks below
  always_comb begin
    for (int i = 0; i < CT_NUM_CH; i++) begin
      clearAll[2*i]   = clearLows[i];
      clearAll[2*i+1] = clearHighs[i];
    end
  end

  // Read channel: answer one cycle after the address is taken
  ct_rd_state_e         rdState;
  ct_rd_state_e         next_rdState;
  logic [CT_DATA_W-1:0] next_rdata;
  logic [1:0]           next_rresp;
  logic [CT_CODE_W-1:0] rdWord;

  always_comb begin
    next_rdState = rdState;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    rdWord       = minCodes[rdCh];
    unique case (rdState)
      CT_RD_IDLE: begin
        if (rdTake) begin
          next_rdState = CT_RD_RESP;
          if (rdHit) begin
            next_rdata = {24'h00_0000, rdHigh ? rdWord[15:8] : rdWord[7:0]};
            next_rresp = CT_RESP_OKAY;
          end else begin
            next_rdata = '0;
            next_rresp = CT_RESP_DECERR;                       // Unmapped read
          end
        end
      end
      CT_RD_RESP: begin
        if (s_axi_rready) begin
          next_rdState = CT_RD_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdState       <= CT_RD_IDLE;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= CT_RESP_OKAY;
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      rdState       <= next_rdState;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
      s_axi_rvalid  <= (next_rdState == CT_RD_RESP);
      s_axi_arready <= (next_rdState == CT_RD_IDLE);
    end
  end

  // Write channel: address and data in either order, then refuse
  ct_wr_state_e   wrState;
  ct_wr_state_e   next_wrState;
  logic           wrHit;
  logic           next_wrHit;
  logic           awTake;
  logic           wTake;

  always_comb begin
    awTake       = s_axi_awvalid && s_axi_awready;
    wTake        = s_axi_wvalid && s_axi_wready;
    next_wrState = wrState;
    next_wrHit   = awTake ? addrHit(s_axi_awaddr) : wrHit;
    unique case (wrState)
      CT_WR_IDLE: begin
        if (awTake && wTake) begin
          next_wrState = CT_WR_RESP;
        end else if (awTake) begin
          next_wrState = CT_WR_ADDR;
        end else if (wTake) begin
          next_wrState = CT_WR_DATA;
        end
      end
      CT_WR_ADDR: begin
        if (wTake) begin
          next_wrState = CT_WR_RESP;
        end
      end
      CT_WR_DATA: begin
        if (awTake) begin
          next_wrState = CT_WR_RESP;
        end
      end
      CT_WR_RESP: begin
        if (s_axi_bready) begin
          next_wrState = CT_WR_IDLE;
        end
      end
    endcase
  end

  // Nothing is writable, so data and strobes are never stored
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wrState       <= CT_WR_IDLE;
      wrHit         <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= CT_RESP_OKAY;
    end else begin
      wrState       <= next_wrState;
      wrHit         <= next_wrHit;
      s_axi_awready <= (next_wrState == CT_WR_IDLE) || (next_wrState == CT_WR_DATA);
      s_axi_wready  <= (next_wrState == CT_WR_IDLE) || (next_wrState == CT_WR_ADDR);
      s_axi_bvalid  <= (next_wrState == CT_WR_RESP);
      s_axi_bresp   <= next_wrHit ? CT_RESP_SLVERR : CT_RESP_DECERR;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence rdMapped;
    rdTake && rdHit;
  endsequence

  sequence rdAnswered;
    s_axi_rvalid && s_axi_rresp == CT_RESP_OKAY && s_axi_rdata[31:8] == 24'h00_0000;
  endsequence

  read_byte_value_a: assert property (
    rdMapped |=> rdAnswered ##0 s_axi_rdata[7:0] ==
      ($past(rdHigh) ? $past(rdWord[15:8]) : $past(rdWord[7:0])))
    else $error("read returned wrong byte");

  write_refused_a: assert property (
    s_axi_bvalid |-> s_axi_bresp != CT_RESP_OKAY)
    else $error("write to read-only bank accepted");

  read_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped before rready");

  // Write: both items in, then one refusal that stands until bready
  sequence wrLastTaken;
    (awTake && wTake) || (awTake && wrState == CT_WR_DATA) ||
      (wTake && wrState == CT_WR_ADDR);
  endsequence

  sequence wrAnswered;
    s_axi_bvalid && !s_axi_awready && !s_axi_wready;
  endsequence

  write_answer_a: assert property (
    wrLastTaken |=> wrAnswered)
    else $error("write answer not given after both items");

  write_resp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped before bready");

  write_resp_done_a: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write channel not ready after answer");

  // A refused write must not disturb any stored minimum
  write_keeps_min_a: assert property (
    (awTake || wTake) && !codeValid && !rdTake
    |=> $stable({minCodes[0], minCodes[1], minCodes[2], minCodes[3]}))
    else $error("write changed a stored minimum");

  // Read-clear: only a mapped read clears, and only its own byte
  clear_onehot_a: assert property (
    $countones(clearAll) <= 1)
    else $error("more than one byte cleared at once");

  clear_needs_read_a: assert property (
    !(rdTake && rdHit) |-> clearAll == '0)
    else $error("byte cleared without a mapped read");

  clear_right_byte_a: assert property (
    rdMapped |-> clearAll[3'(s_axi_araddr[CT_ADDR_W-1:2] - CT_IDX_IN1_LOW)])
    else $error("read cleared the wrong byte");

  // Read handshake timing
  read_latency_a: assert property (
    rdTake |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer not one cycle after address");

  read_release_a: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read channel not ready after answer");

  read_unmapped_a: assert property (
    rdTake && !rdHit |=> s_axi_rresp == CT_RESP_DECERR && s_axi_rdata == '0)
    else $error("unmapped read not refused");

  ready_excl_a: assert property (
    !(s_axi_rvalid && s_axi_arready))
    else $error("new read address accepted while answer pending");

  // Codes reach only the tracker of their own channel
  sample_routed_a: assert property (
    codeValid && codeChannel == CT_FIRST_CH |-> trk[0].sampleValid && !trk[1].sampleValid)
    else $error("code for first channel misrouted");

  sample_ignored_a: assert property (
    codeValid && (codeChannel < CT_FIRST_CH || codeChannel > CT_FIRST_CH + 3'(CT_NUM_CH - 1))
    |-> !trk[0].sampleValid && !trk[1].sampleValid && !trk[2].sampleValid &&
        !trk[3].sampleValid)
    else $error("code for an untracked channel stored");

endmodule : ct_min_bank

`default_nettype wire

// File: tb/ct_axi_host.sv
/*
  AXI4-Lite master standing in for the host controller that reads the bank.
  Assumes a registered slave on clk_sys; the bench's timeout bounds every wait.
*/
`default_nettype none

module ct_axi_host (
  input  wire logic                     clk_sys,
  output logic [ct_pkg::CT_ADDR_W-1:0]  s_axi_awaddr,
  output logic                          s_axi_awvalid,
  input  wire logic                     s_axi_awready,
  output logic [ct_pkg::CT_DATA_W-1:0]  s_axi_wdata,
  output logic [3:0]                    s_axi_wstrb,
  output logic                          s_axi_wvalid,
  input  wire logic                     s_axi_wready,
  input  wire logic [1:0]               s_axi_bresp,
  input  wire logic                     s_axi_bvalid,
  output logic                          s_axi_bready,
  output logic [ct_pkg::CT_ADDR_W-1:0]  s_axi_araddr,
  output logic                          s_axi_arvalid,
  input  wire logic                     s_axi_arready,
  input  wire logic [ct_pkg::CT_DATA_W-1:0] s_axi_rdata,
  input  wire logic [1:0]               s_axi_rresp,
  input  wire logic                     s_axi_rvalid,
  output logic                          s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ns;
  import ct_pkg::*;

  // Idle bus at time zero
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end

  // One read; a released address shows its inverse, never the old value
  task automatic rd(input logic [CT_ADDR_W-1:0] a, output logic [CT_DATA_W-1:0] d,
                    output logic [1:0] r);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge clk_sys); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr  <= ~a;
    do @(posedge clk_sys); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk_sys);
  endtask

  // One write; address and data offered together, each released when taken
  task automatic wr(input logic [CT_ADDR_W-1:0] a, input logic [CT_DATA_W-1:0] d,
                    output logic [1:0] r);
    logic awDone = 1'b0;
    logic wDone  = 1'b0;
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hF;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(awDone && wDone)) begin
      @(posedge clk_sys);
      if (s_axi_awready && !awDone) begin
        awDone = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !wDone) begin
        wDone = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk_sys); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk_sys);
  endtask
endmodule // ct_axi_host

`default_nettype wire

// File: tb/testbench.sv
/*
  Self-checking bench for the lowest-code register bank.
  Assumes ct_axi_host as register master and one 10 MHz clock.
*/
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import ct_pkg::*;

  logic                  clk_sys, nrst, codeValid;
  logic [CT_CHSEL_W-1:0] codeChannel;
  logic [CT_CODE_W-1:0]  code;
  logic [CT_ADDR_W-1:0]  s_axi_awaddr, s_axi_araddr;
  logic [CT_DATA_W-1:0]  s_axi_wdata, s_axi_rdata;
  logic [3:0]            s_axi_wstrb;
  logic [1:0]            s_axi_bresp, s_axi_rresp;
  logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                  s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                  s_axi_rvalid, s_axi_rready;
  logic [7:0]            mLo [1:4];
  logic [7:0]            mHi [1:4];
  logic [31:0]           rng = 32'h0000_004A;
  int                    err_total = 0;
  int                    compares = 0;
  int                    cycles = 0;

  ct_min_bank i_ct_min_bank (.clk_sys, .nrst, .codeValid, .codeChannel, .code,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  ct_axi_host i_ct_axi_host (.clk_sys,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);

  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Xorshift source, fixed seed keeps runs repeatable
  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  // Byte address: index 0x80 + 2*channel (+1 for high byte), four bytes a word
  function automatic logic [CT_ADDR_W-1:0] regAddr(input int ch, input logic hi);
    return CT_ADDR_W'((32'h0000_0080 + 2 * ch + int'(hi)) * 4);
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Read one byte, compare with the model, then restore the model byte
  task automatic readByte(input int ch, input logic hi);
    logic [31:0] d;
    logic [1:0]  r;
    i_ct_axi_host.rd(regAddr(ch, hi), d, r);
    check("rresp", 32'(r), 32'(CT_RESP_OKAY));
    check("rdata", d, {24'h00_0000, hi ? mHi[ch] : mLo[ch]});
    if (hi)
      mHi[ch] = CT_LOWEST_RESET;
    else
      mLo[ch] = CT_LOWEST_RESET;
  endtask

  // One code strobe; the code input shows junk between strobes
  task automatic sendCode(input logic [CT_CHSEL_W-1:0] ch, input logic [CT_CODE_W-1:0] c);
    codeValid   <= 1'b1;
    codeChannel <= ch;
    code        <= c;
    @(posedge clk_sys);
    codeValid   <= 1'b0;
    code        <= ~c;
    @(posedge clk_sys);
    if (ch >= 1 && ch <= 4 && c < {mHi[ch], mLo[ch]})
      {mHi[ch], mLo[ch]} = c;
  endtask

  task automatic writeTry(input logic [CT_ADDR_W-1:0] a, input logic [1:0] exp);
    logic [1:0] r;
    i_ct_axi_host.wr(a, rnd(), r);
    check("bresp", 32'(r), 32'(exp));
  endtask

  // Hang guard, far above the roughly 1000 cycles the run needs
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 8000) begin
      err_total++;
      final_report();
    end
  end

  initial begin
    logic [31:0] d, v;
    logic [1:0]  r;
    nrst = 1'b0;
    codeValid = 1'b0;
    codeChannel = '0;
    code = '0;
    for (int i = 1; i <= 4; i++) begin
      mLo[i] = 8'hFF;
      mHi[i] = 8'hFF;
    end
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    for (int i = 0; i < 8; i++) readByte(1 + i / 2, i[0]);
    // Writes refused and leave the bytes alone
    writeTry(regAddr(2, 1'b0), CT_RESP_SLVERR);
    writeTry(12'h3FC, CT_RESP_DECERR);
    readByte(2, 1'b0);
    // Channel 0 and a misaligned address are outside the bank
    for (int k = 0; k < 2; k++) begin
      i_ct_axi_host.rd(k == 0 ? 12'h200 : 12'h209, d, r);
      check("rresp", 32'(r), 32'(CT_RESP_DECERR));
      check("rdata", d, 32'h0000_0000);
    end
    // Corners: equal code, zero code, split-byte compare after high clear
    sendCode(3'h1, 16'hFFFF);
    sendCode(3'h4, 16'h0000);
    sendCode(3'h3, 16'h1234);
    readByte(3, 1'b1);
    sendCode(3'h3, 16'h1235);
    for (int i = 0; i < 8; i++) readByte(1 + i / 2, i[0]);
    // Code and read-clear on one edge: the cleared byte then takes the code
    fork
      i_ct_axi_host.rd(regAddr(1, 1'b0), d, r);
      sendCode(3'h1, 16'h1234);
    join
    check("rresp", 32'(r), 32'(CT_RESP_OKAY));
    check("rdata", d, {24'h00_0000, CT_LOWEST_RESET});
    // Random traffic on all eight channel numbers
    repeat (300) begin
      v = rnd();
      sendCode(v[2:0], v[18:3]);
      if (v[31:30] == 2'b00) readByte(1 + int'(v[21:20]), v[22]);
    end
    for (int i = 0; i < 8; i++) readByte(1 + i / 2, i[0]);
    for (int i = 0; i < 8; i++) readByte(1 + i / 2, i[0]);
    // Mid-run reset with stored codes: every byte back to all ones
    sendCode(3'h2, 16'h0101);
    sendCode(3'h4, 16'h8000);
    nrst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    for (int i = 1; i <= 4; i++) begin
      mLo[i] = CT_LOWEST_RESET;
      mHi[i] = CT_LOWEST_RESET;
    end
    @(posedge clk_sys);
    for (int i = 0; i < 8; i++) readByte(1 + i / 2, i[0]);
    final_report();
  end
endmodule // testbench

`default_nettype wire
